// ===== pkg/adf_pkg.sv
// Package for the record-side digital filter path: register map, fields, tables, carriers
`default_nettype none
package adf_pkg;
    localparam int SAMPLE_W = 24;
    localparam int REG_W    = 9;
    localparam int ADDR_W   = 7;
    localparam int HALF_W   = 7;
    // Register offsets
    localparam logic [6:0] ADDR_POWER  = 7'h02;
    localparam logic [6:0] ADDR_RATE   = 7'h07;
    localparam logic [6:0] ADDR_CTRL   = 7'h0E;
    localparam logic [6:0] ADDR_VOLUME = 7'h0F;
    localparam logic [6:0] ADDR_A0_HI  = 7'h1B;
    localparam logic [6:0] ADDR_A0_LO  = 7'h1C;
    localparam logic [6:0] ADDR_A1_HI  = 7'h1D;
    localparam logic [6:0] ADDR_A1_LO  = 7'h1E;
    // Field positions
    localparam int BIT_PATH_EN   = 0;
    localparam int RATE_LSB      = 1;
    localparam int RATE_MSB      = 3;
    localparam int BIT_INVERT    = 0;
    localparam int BIT_OSR       = 3;
    localparam int CUT_LSB       = 4;
    localparam int CUT_MSB       = 6;
    localparam int BIT_HPF_MODE  = 7;
    localparam int BIT_HPF_EN    = 8;
    localparam int BIT_NOTCH_EN  = 7;
    localparam int BIT_COEF_LOAD = 8;
    // Reset values
    localparam logic [8:0] CTRL_RST   = 9'h000;
    localparam logic [7:0] VOLUME_RST = 8'hFF;
    localparam logic [6:0] HALF_RST   = 7'h00;
    localparam logic [2:0] RATE_RST   = 3'h0;
    // Decimation
    localparam logic [7:0] OSR_LOW        = 8'h40;
    localparam logic [7:0] OSR_HIGH       = 8'h80;
    localparam int         DEC_SHIFT_LOW  = 16;
    localparam int         DEC_SHIFT_HIGH = 15;
    // High-pass: state fraction bits, audio-mode shift, coefficient fraction
    localparam int HPF_FRAC        = 8;
    localparam int AUDIO_HPF_SHIFT = 11;
    localparam int COEF_FRAC       = 16;
    // 2*pi*fc/fs in Q16 per cutoff code, for the lowest rate of a rate group
    localparam logic [15:0] HPF_COEF [0:7] = '{16'h107C, 16'h1482, 16'h1A56, 16'h20C5,
                                               16'h2903, 16'h3479, 16'h41BE, 16'h5206};
    // Notch coefficient fraction bits
    localparam int A0_FRAC = 13;
    localparam int A1_FRAC = 12;
    // Volume: 0.5 dB steps, twelve per 6 dB, Q15 mantissas
    localparam logic [7:0] VOL_UNITY     = 8'hFF;
    localparam logic [7:0] VOL_MUTE      = 8'h00;
    localparam logic [7:0] VOL_STEPS_6DB = 8'h0C;
    localparam int         VOL_FRAC      = 15;
    localparam logic [15:0] VOL_MANT [0:11] = '{16'h8000, 16'h78D7, 16'h7215, 16'h6BB3,
                                                16'h65AD, 16'h5FFD, 16'h5A9E, 16'h558C,
                                                16'h50C3, 16'h4C3F, 16'h47FB, 16'h43F4};
    // Saturation bounds
    localparam logic signed [39:0] SAT_MAX = 40'sh00007FFFFF;
    localparam logic signed [39:0] SAT_MIN = 40'shFFFF800000;

    // Register write carrier
    typedef struct packed {
        logic                  en;
        logic [ADDR_W-1:0]     addr;
        logic [REG_W-1:0]      data;
    } adf_reg_wr_type;
endpackage
`default_nettype wire

// ===== design/adf_sample_buffer.sv
// Two-entry sample buffer with valid and ready on both sides
`default_nettype none
module adf_sample_buffer #(
    parameter int WIDTH = adf_pkg::SAMPLE_W
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    import adf_pkg::*;

    logic             v0_r;
    logic             v1_r;
    logic [WIDTH-1:0] d0_r;
    logic [WIDTH-1:0] d1_r;

    // Pop shifts the tail to the head, push fills the first free slot
    wire             popNow  = v0_r & outReady;
    wire             pushNow = inValid & ~v1_r;
    wire             shV0    = popNow ? v1_r : v0_r;
    wire             shV1    = popNow ? 1'b0 : v1_r;
    wire [WIDTH-1:0] shD0    = popNow ? d1_r : d0_r;
    wire             v0_nxt  = shV0 | pushNow;
    wire             v1_nxt  = shV1 | (pushNow & shV0);
    wire [WIDTH-1:0] d0_nxt  = (pushNow & ~shV0) ? inData : shD0;
    wire [WIDTH-1:0] d1_nxt  = (pushNow & shV0) ? inData : d1_r;

    // Slot state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            v0_r <= 1'b0;
            v1_r <= 1'b0;
        end else begin
            v0_r <= v0_nxt;
            v1_r <= v1_nxt;
        end
    end

    // Slot data
    always_ff @(posedge ref_clk) begin
        d0_r <= d0_nxt;
        d1_r <= d1_nxt;
    end

    // Ready only while the tail slot is free
    assign inReady  = ~v1_r;
    assign outValid = v0_r;
    assign outData  = d0_r;
endmodule
`default_nettype wire

// ===== design/adf_record_path.sv
// Record-side digital path: decimation, high-pass, notch, volume, polarity, output buffer
`default_nettype none
module adf_record_path (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_n,
    input  wire adf_pkg::adf_reg_wr_type       regWr,
    input  wire logic [adf_pkg::ADDR_W-1:0]    regRdAddr,
    output logic      [adf_pkg::REG_W-1:0]     regRdData,
    input  wire logic                          modBit,
    input  wire logic                          modStrobe,
    output logic      [adf_pkg::SAMPLE_W-1:0]  recSample,
    output logic                               recValid,
    input  wire logic                          recReady,
    output logic                               recOverrun
);
    import adf_pkg::*;

    // Saturate a wide signed value into a sample
    function automatic logic signed [23:0] sat24(input logic signed [39:0] v);
        logic signed [23:0] r;
        r = v[23:0];
        if (v > SAT_MAX) begin
            r = SAT_MAX[23:0];
        end else if (v < SAT_MIN) begin
            r = SAT_MIN[23:0];
        end
        return r;
    endfunction

    // ---------------- Register file ----------------
    logic                     pathEn_r;
    logic [2:0]               rateSel_r;
    logic [8:0]               filtCtrl_r;
    logic [7:0]               volCode_r;
    logic                     notchEn_r;
    logic [HALF_W-1:0]        a0Hi_r;
    logic [HALF_W-1:0]        a0Lo_r;
    logic [HALF_W-1:0]        a1Hi_r;
    logic [HALF_W-1:0]        a1Lo_r;
    logic signed [13:0]       coefA0_r;
    logic signed [13:0]       coefA1_r;
    logic [REG_W-1:0]         regRdData_r;
    logic                     overrun_r;

    // Write decode
    wire wrPower = regWr.en && (regWr.addr == ADDR_POWER);
    wire wrRate  = regWr.en && (regWr.addr == ADDR_RATE);
    wire wrCtrl  = regWr.en && (regWr.addr == ADDR_CTRL);
    wire wrVol   = regWr.en && (regWr.addr == ADDR_VOLUME);
    wire wrA0Hi  = regWr.en && (regWr.addr == ADDR_A0_HI);
    wire wrA0Lo  = regWr.en && (regWr.addr == ADDR_A0_LO);
    wire wrA1Hi  = regWr.en && (regWr.addr == ADDR_A1_HI);
    wire wrA1Lo  = regWr.en && (regWr.addr == ADDR_A1_LO);
    wire wrNotch = wrA0Hi | wrA0Lo | wrA1Hi | wrA1Lo;
    wire coefLoad = wrNotch && regWr.data[BIT_COEF_LOAD];

    // Staged halves including the value of the current write
    wire [HALF_W-1:0] a0Hi_nxt = wrA0Hi ? regWr.data[HALF_W-1:0] : a0Hi_r;
    wire [HALF_W-1:0] a0Lo_nxt = wrA0Lo ? regWr.data[HALF_W-1:0] : a0Lo_r;
    wire [HALF_W-1:0] a1Hi_nxt = wrA1Hi ? regWr.data[HALF_W-1:0] : a1Hi_r;
    wire [HALF_W-1:0] a1Lo_nxt = wrA1Lo ? regWr.data[HALF_W-1:0] : a1Lo_r;

    // Software-visible registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pathEn_r   <= 1'b0;
            rateSel_r  <= RATE_RST;
            filtCtrl_r <= CTRL_RST;
            volCode_r  <= VOLUME_RST;
            notchEn_r  <= 1'b0;
        end else begin
            if (wrPower) pathEn_r <= regWr.data[BIT_PATH_EN];
            if (wrRate) rateSel_r <= regWr.data[RATE_MSB:RATE_LSB];
            if (wrCtrl) filtCtrl_r <= regWr.data;
            if (wrVol) volCode_r <= regWr.data[7:0];
            if (wrA0Hi) notchEn_r <= regWr.data[BIT_NOTCH_EN];
        end
    end

    // Staged coefficient halves
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            a0Hi_r <= HALF_RST;
            a0Lo_r <= HALF_RST;
            a1Hi_r <= HALF_RST;
            a1Lo_r <= HALF_RST;
        end else begin
            a0Hi_r <= a0Hi_nxt;
            a0Lo_r <= a0Lo_nxt;
            a1Hi_r <= a1Hi_nxt;
            a1Lo_r <= a1Lo_nxt;
        end
    end

    // Live coefficients, both replaced in the same edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            coefA0_r <= {HALF_RST, HALF_RST};
            coefA1_r <= {HALF_RST, HALF_RST};
        end else if (coefLoad) begin
            coefA0_r <= {a0Hi_nxt, a0Lo_nxt};
            coefA1_r <= {a1Hi_nxt, a1Lo_nxt};
        end
    end

    // Read selection; load bit always reads back as zero
    wire [REG_W-1:0] rdMux =
        (regRdAddr == ADDR_POWER)  ? {8'h00, pathEn_r} :
        (regRdAddr == ADDR_RATE)   ? {5'h00, rateSel_r, 1'b0} :
        (regRdAddr == ADDR_CTRL)   ? filtCtrl_r :
        (regRdAddr == ADDR_VOLUME) ? {1'b0, volCode_r} :
        (regRdAddr == ADDR_A0_HI)  ? {1'b0, notchEn_r, a0Hi_r} :
        (regRdAddr == ADDR_A0_LO)  ? {2'b00, a0Lo_r} :
        (regRdAddr == ADDR_A1_HI)  ? {2'b00, a1Hi_r} :
        (regRdAddr == ADDR_A1_LO)  ? {2'b00, a1Lo_r} : '0;

    // Registered read port
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            regRdData_r <= '0;
        end else begin
            regRdData_r <= rdMux;
        end
    end

    // ---------------- Decimator ----------------
    logic [7:0] bitCnt_r;
    logic [7:0] onesCnt_r;

    wire [7:0]         osrLen   = filtCtrl_r[BIT_OSR] ? OSR_HIGH : OSR_LOW;
    wire               lastBit  = modStrobe && (bitCnt_r == (osrLen - 8'h01));
    wire [7:0]         onesNow  = onesCnt_r + {7'h00, modBit};
    // Ones density mapped to a signed value of +-osrLen
    wire signed [9:0]  decDiff  = $signed({1'b0, onesNow, 1'b0}) - $signed({2'b00, osrLen});
    wire signed [23:0] decExt   = {{14{decDiff[9]}}, decDiff};
    // Full scale lands at 2^22 for either ratio
    wire signed [23:0] decSample = filtCtrl_r[BIT_OSR] ? (decExt <<< DEC_SHIFT_HIGH)
                                                       : (decExt <<< DEC_SHIFT_LOW);
    wire               decValid = lastBit && pathEn_r;

    // Bitstream counting; restarts when disabled or reconfigured
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !pathEn_r || wrCtrl) begin
            bitCnt_r  <= '0;
            onesCnt_r <= '0;
        end else if (modStrobe) begin
            bitCnt_r  <= lastBit ? 8'h00 : bitCnt_r + 8'h01;
            onesCnt_r <= lastBit ? 8'h00 : onesNow;
        end
    end

    // ---------------- Stage sequencing ----------------
    logic               p1_r;
    logic               p2_r;
    logic               finV_r;
    logic signed [23:0] hpfY_r;
    logic signed [23:0] notchY_r;
    logic signed [23:0] finY_r;
    wire                bufReady;

    wire finTaken = finV_r & bufReady;
    wire busy     = p1_r | p2_r | (finV_r & ~finTaken);
    wire accept   = decValid & ~busy;
    wire drop     = decValid & busy;

    // ---------------- High-pass ----------------
    logic signed [31:0] dcA_r;
    logic signed [31:0] dcB_r;

    wire               highpass_enable    = filtCtrl_r[BIT_HPF_EN];
    wire               hpfMode  = filtCtrl_r[BIT_HPF_MODE];
    wire [2:0]         cutSel   = filtCtrl_r[CUT_MSB:CUT_LSB];
    // Rate groups share cutoff-to-rate ratios, halving per group step
    wire [1:0]         rateGrp  = rateSel_r[2] ? 2'h0 : (rateSel_r[1] ? 2'h1 : 2'h2);
    wire signed [16:0] cutCoef  = $signed({1'b0, HPF_COEF[cutSel]});
    wire [5:0]         coefShift = 6'(COEF_FRAC) + {4'h0, rateGrp};
    wire signed [31:0] hpfIn    = {{8{decSample[23]}}, decSample};
    // Each section tracks the DC level and subtracts it
    wire signed [31:0] errA     = (hpfIn <<< HPF_FRAC) - dcA_r;
    wire signed [31:0] yA       = hpfIn - (dcA_r >>> HPF_FRAC);
    wire signed [31:0] errB     = (yA <<< HPF_FRAC) - dcB_r;
    wire signed [31:0] yB       = yA - (dcB_r >>> HPF_FRAC);
    wire signed [48:0] prodA    = errA * cutCoef;
    wire signed [48:0] prodB    = errB * cutCoef;
    wire signed [31:0] stepA    = hpfMode ? 32'(prodA >>> coefShift)
                                          : (errA >>> AUDIO_HPF_SHIFT);
    wire signed [31:0] stepB    = 32'(prodB >>> coefShift);
    wire signed [31:0] hpfRaw   = !highpass_enable ? hpfIn : (hpfMode ? yB : yA);

    // Section states move once per accepted sample
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !pathEn_r || !highpass_enable) begin
            dcA_r <= '0;
            dcB_r <= '0;
        end else if (accept) begin
            dcA_r <= dcA_r + stepA;
            dcB_r <= hpfMode ? dcB_r + stepB : 32'sh0;
        end
    end

    // ---------------- Notch ----------------
    logic signed [31:0] w1_r;
    logic signed [31:0] w2_r;

    // All-pass section; notch is the mean of input and all-pass output
    wire signed [31:0] nx       = {{8{hpfY_r[23]}}, hpfY_r};
    wire signed [45:0] c1w1     = coefA1_r * w1_r;
    wire signed [45:0] c0w2     = coefA0_r * w2_r;
    wire signed [31:0] nw       = nx + 32'(c1w1 >>> A1_FRAC) + 32'(c0w2 >>> A0_FRAC);
    wire signed [45:0] c0w      = coefA0_r * nw;
    wire signed [31:0] nap      = w2_r - 32'(c0w >>> A0_FRAC) - 32'(c1w1 >>> A1_FRAC);
    wire signed [39:0] nxWide   = {{8{nx[31]}}, nx};
    wire signed [39:0] notchSum = nxWide + {{8{nap[31]}}, nap};
    wire signed [39:0] notchRaw = notchEn_r ? (notchSum >>> 1) : nxWide;

    // All-pass delay line
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !pathEn_r || !notchEn_r) begin
            w1_r <= '0;
            w2_r <= '0;
        end else if (p1_r) begin
            w1_r <= nw;
            w2_r <= w1_r;
        end
    end

    // ---------------- Volume and polarity ----------------
    wire [7:0]         atten     = VOL_UNITY - volCode_r;
    wire [3:0]         mantIdx   = 4'(atten % VOL_STEPS_6DB);
    wire [4:0]         octShift  = 5'(atten / VOL_STEPS_6DB);
    wire signed [40:0] volProd   = notchY_r * $signed({1'b0, VOL_MANT[mantIdx]});
    wire [5:0]         volShift  = 6'(VOL_FRAC) + {1'b0, octShift};
    wire signed [40:0] volScaled = volProd >>> volShift;
    wire signed [23:0] volOut    = (volCode_r == VOL_MUTE) ? 24'sh0 : volScaled[23:0];
    wire signed [39:0] negWide   = -{{16{volOut[23]}}, volOut};
    wire signed [23:0] finNxt    = filtCtrl_r[BIT_INVERT] ? sat24(negWide) : volOut;

    // Stage valids; a held output blocks new samples
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !pathEn_r) begin
            p1_r   <= 1'b0;
            p2_r   <= 1'b0;
            finV_r <= 1'b0;
        end else begin
            p1_r   <= accept;
            p2_r   <= p1_r;
            finV_r <= p2_r | (finV_r & ~finTaken);
        end
    end

    // Stage data, 24 bits between every stage
    always_ff @(posedge ref_clk) begin
        if (accept) hpfY_r <= sat24({{8{hpfRaw[31]}}, hpfRaw});
        if (p1_r) notchY_r <= sat24(notchRaw);
        if (p2_r) finY_r <= finNxt;
    end

    // Sticky drop flag; a new drop wins over the clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            overrun_r <= 1'b0;
        end else begin
            overrun_r <= drop | (overrun_r & ~wrPower);
        end
    end

    // Output buffer toward the sample consumer
    adf_sample_buffer #(
        .WIDTH (SAMPLE_W)
    ) u_buffer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .inValid  (finV_r),
        .inData   (finY_r),
        .inReady  (bufReady),
        .outValid (recValid),
        .outData  (recSample),
        .outReady (recReady)
    );

    assign regRdData  = regRdData_r;
    assign recOverrun = overrun_r;
endmodule
`default_nettype wire

// ===== verif/adf_record_path_chk.sv
// Port checker for the record path, bound to the top module
`default_nettype none
module adf_record_path_chk (
    input wire logic                    ref_clk,
    input wire logic                    rst_n,
    input wire adf_pkg::adf_reg_wr_type regWr,
    input wire logic [6:0]              regRdAddr,
    input wire logic [8:0]              regRdData,
    input wire logic                    modBit,
    input wire logic                    modStrobe,
    input wire logic [23:0]             recSample,
    input wire logic                    recValid,
    input wire logic                    recReady,
    input wire logic                    recOverrun
);
    import adf_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Read decode and the write that clears the overrun flag
    wire notchRd = regRdAddr >= ADDR_A0_HI && regRdAddr <= ADDR_A1_LO;
    wire mapRd   = notchRd || regRdAddr == ADDR_POWER || regRdAddr == ADDR_RATE
                   || regRdAddr == ADDR_CTRL || regRdAddr == ADDR_VOLUME;
    wire clrWr   = regWr.en && regWr.addr == ADDR_POWER;
    // Write then quiet read of one address
    sequence s_wrTo(logic [6:0] a);
        regWr.en && regWr.addr == a;
    endsequence
    sequence s_rdOf(logic [6:0] a);
        !regWr.en && regRdAddr == a;
    endsequence
    property p_volBack;
        s_wrTo(ADDR_VOLUME) ##1 s_rdOf(ADDR_VOLUME) |=> regRdData[7:0] == $past(regWr.data[7:0], 2);
    endproperty
    a_volBack: assert property (p_volBack) else $error("volume readback wrong");
    property p_ctrlBack;
        s_wrTo(ADDR_CTRL) ##1 s_rdOf(ADDR_CTRL)
            |=> {regRdData[8:3], regRdData[0]} == $past({regWr.data[8:3], regWr.data[0]}, 2);
    endproperty
    a_ctrlBack: assert property (p_ctrlBack) else $error("control readback wrong");
    property p_notchB8;
        notchRd |=> !regRdData[8];
    endproperty
    a_notchB8: assert property (p_notchB8) else $error("load bit read back");
    property p_unmap;
        !mapRd |=> regRdData == 9'h000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold;
        recValid && !recReady |=> recValid && $stable(recSample);
    endproperty
    a_hold: assert property (p_hold) else $error("sample lost under stall");
    property p_stick;
        recOverrun && !clrWr |=> recOverrun;
    endproperty
    a_stick: assert property (p_stick) else $error("overrun flag not sticky");
    property p_cause;
        $rose(recOverrun) |-> $past(recValid);
    endproperty
    a_cause: assert property (p_cause) else $error("overrun without full buffer");
    property p_rdStable;
        !regWr.en ##1 $stable(regRdAddr) |=> $stable(regRdData);
    endproperty
    a_rdStable: assert property (p_rdStable) else $error("read data moved without write");
endmodule
bind adf_record_path adf_record_path_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .regWr(regWr),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .modBit(modBit), .modStrobe(modStrobe),
    .recSample(recSample), .recValid(recValid), .recReady(recReady), .recOverrun(recOverrun));
`default_nettype wire

// ===== verif/adf_mod_source.sv
// Behavioural modulator bitstream source, one frame per go pulse
`default_nettype none
module adf_mod_source (
    input  wire logic       ref_clk,
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic [7:0] osr,
    input  wire logic [7:0] ones,
    output logic            modBit,
    output logic            modStrobe,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 100ps;
    int i;
    // Ones first, then zeros; idle bit flips so it is never stale
    initial begin
        modBit = 1'b0;
        modStrobe = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (go === 1'b1) begin
                #1 busy = 1'b1;
                for (i = 0; i < osr; i++) begin
                    modStrobe = 1'b1;
                    modBit = (i < ones);
                    @(posedge ref_clk); #1;
                    if (slow) begin
                        modStrobe = 1'b0; // Slow source: gap cycle
                        modBit = ~modBit;
                        @(posedge ref_clk); #1;
                    end
                end
                modStrobe = 1'b0;
                modBit = ~modBit;
                busy = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the record path
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import adf_pkg::*;
    typedef struct {
        logic [8:0]  ctrl;
        logic [7:0]  vol;
        logic [7:0]  ones;
        logic [23:0] exp;
    } adf_row_type;
    logic           ref_clk = 1'b0;
    logic           rst_n = 1'b0;
    adf_reg_wr_type regWr = '0;
    logic [6:0]     regRdAddr = 7'h00;
    logic [8:0]     regRdData;
    logic           modBit, modStrobe, busy, recValid, recOverrun;
    logic           recReady = 1'b0;
    logic           go = 1'b0;
    logic           slow = 1'b0;
    logic [7:0]     srcOsr = OSR_LOW;
    logic [7:0]     srcOnes = 8'h00;
    logic [23:0]    recSample, smp;
    int             errors = 0;
    int             checks_done = 0;
    logic [8:0]     hpfModes [2] = '{9'h100, 9'h180};
    logic [23:0]    notchExp [3] = '{24'h200000, 24'h200000, 24'h400000};
    // Settings, ones per frame, expected sample
    adf_row_type    rows [9] = '{
        '{9'h000, 8'hFF, 8'h40, 24'h400000}, '{9'h000, 8'hFF, 8'h00, 24'hC00000},
        '{9'h008, 8'hFF, 8'h80, 24'h400000}, '{9'h008, 8'hFF, 8'h60, 24'h200000},
        '{9'h001, 8'hFF, 8'h40, 24'hC00000}, '{9'h000, 8'h00, 8'h40, 24'h000000},
        '{9'h000, 8'hFD, 8'h40, 24'h390A80}, '{9'h000, 8'hF3, 8'h40, 24'h200000},
        '{9'h001, 8'hFF, 8'h00, 24'h400000}};
    adf_record_path dut (.ref_clk(ref_clk), .rst_n(rst_n), .regWr(regWr), .regRdAddr(regRdAddr),
        .regRdData(regRdData), .modBit(modBit), .modStrobe(modStrobe), .recSample(recSample),
        .recValid(recValid), .recReady(recReady), .recOverrun(recOverrun));
    adf_mod_source src (.ref_clk(ref_clk), .go(go), .slow(slow), .osr(srcOsr), .ones(srcOnes),
        .modBit(modBit), .modStrobe(modStrobe), .busy(busy));
    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    task automatic results;
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
            errors++;
        end
    endtask
    // Write strobe stays up until the next rd or frame task drops it
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        regWr = '{en: 1'b1, addr: a, data: d};
        @(posedge ref_clk); #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] exp);
        regWr.en = 1'b0;
        regRdAddr = a;
        @(posedge ref_clk); #1;
        chk({15'h0, regRdData}, {15'h0, exp});
    endtask
    task automatic frame(input logic [7:0] ones);
        int n;
        regWr.en = 1'b0;
        srcOnes = ones;
        go = 1'b1;
        @(posedge ref_clk); #1;
        go = 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk); #1;
            n++;
        end while (busy === 1'b1 && n < 600);
    endtask
    task automatic take(output logic [23:0] s);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk); #1;
            n++;
        end while (recValid !== 1'b1 && n < 60);
        chk({23'h0, recValid}, 24'h1);
        s = recSample;
        recReady = 1'b1;
        @(posedge ref_clk); #1;
        recReady = 1'b0;
    endtask
    // Watchdog
    initial begin
        #200000;
        errors++;
        results();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        chk({22'h0, recValid, recOverrun}, 24'h0);
        rd(ADDR_VOLUME, 9'h0FF);
        rd(ADDR_CTRL, 9'h000);
        rd(ADDR_A0_HI, 9'h000);
        rd(7'h10, 9'h000);
        // Load bit is not stored; staged halves and, at ADDR_A0_HI, the notch enable read back
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_A0_HI + k[6:0], 9'h155);
            rd(ADDR_A0_HI + k[6:0], 9'h055);
        end
        wr(ADDR_A0_HI, 9'h1AA);
        rd(ADDR_A0_HI, 9'h0AA);
        wr(ADDR_A0_HI, 9'h000);
        wr(ADDR_POWER, 9'h001);
        for (int k = 0; k < 9; k++) begin
            wr(ADDR_VOLUME, {1'b0, rows[k].vol});
            rd(ADDR_VOLUME, {1'b0, rows[k].vol});
            wr(ADDR_CTRL, rows[k].ctrl);
            rd(ADDR_CTRL, rows[k].ctrl);
            srcOsr = rows[k].ctrl[BIT_OSR] ? OSR_HIGH : OSR_LOW;
            frame(rows[k].ones);
            take(smp);
            chk(smp, rows[k].exp);
        end
        // Stalled consumer: two buffered, third held at the output stage, fourth dropped
        wr(ADDR_CTRL, 9'h000);
        srcOsr = OSR_LOW;
        slow = 1'b1;
        frame(8'h40);
        frame(8'h00);
        frame(8'h40);
        frame(8'h00);
        slow = 1'b0;
        chk({23'h0, recOverrun}, 24'h1);
        take(smp);
        chk(smp, 24'h400000);
        take(smp);
        chk(smp, 24'hC00000);
        recReady = 1'b1;
        repeat (10) @(posedge ref_clk);
        #1 recReady = 1'b0;
        wr(ADDR_POWER, 9'h001);
        chk({23'h0, recOverrun}, 24'h0);
        // Path off: strobes give no sample
        wr(ADDR_POWER, 9'h000);
        frame(8'h40);
        repeat (8) @(posedge ref_clk);
        #1 chk({23'h0, recValid}, 24'h0);
        wr(ADDR_POWER, 9'h001);
        // Zero codes put band and centre at a quarter of fs: response is (x + x delayed by two) / 2
        wr(ADDR_A0_LO, 9'h000);
        wr(ADDR_A1_HI, 9'h000);
        wr(ADDR_A1_LO, 9'h000);
        wr(ADDR_A0_HI, 9'h180);
        wr(ADDR_A1_LO, 9'h07F);
        foreach (notchExp[j]) begin
            frame(8'h40);
            take(smp);
            chk(smp, notchExp[j]);
        end
        wr(ADDR_A0_HI, 9'h000);
        wr(ADDR_RATE, 9'h00A);
        rd(ADDR_RATE, 9'h00A);
        // High-pass on a steady level: output falls below the input
        foreach (hpfModes[m]) begin
            wr(ADDR_CTRL, hpfModes[m]);
            repeat (3) begin
                frame(8'h40);
                take(smp);
            end
            checks_done++;
            if (!($signed(smp) > 0 && $signed(smp) < 24'sh400000)) begin
                $display("BAD at %0t: got %h expected below %h", $time, smp, 24'h400000);
                errors++;
            end
        end
        results();
    end
endmodule
`default_nettype wire
